// [rtl/cbm_pkg.sv]
/*
  Shared constants, types and decode helpers of the CAN bit timing and
  message buffer block.
  Assumes a 200 MHz core clock and an 8-bit CPU port on a 128-byte window.
*/
package cbm_pkg;

  // ****************************************
  // Clocking and rates
  // ****************************************
  localparam int CLK_MHZ = 200;
  localparam int RATE_MIN_KBPS = 10;
  localparam int RATE_MAX_KBPS = 1000;
  localparam int MIN_BIT_TQ = 7;
  localparam int MAX_BIT_TQ = 25;
  localparam int PRESC_W = 10;

  // ****************************************
  // Register map inside the window
  // ****************************************
  localparam logic [6:0] OFS_MCTL1 = 7'h01;
  localparam logic [6:0] OFS_BT0 = 7'h02;
  localparam logic [6:0] OFS_BT1 = 7'h03;
  localparam logic [6:0] OFS_PRESC_HI = 7'h04;
  localparam logic [6:0] OFS_TXREQ = 7'h05;
  localparam logic [6:0] OFS_STAT = 7'h06;
  localparam logic [2:0] BUF_RX = 3'h4;
  localparam logic [3:0] F_DLC = 4'hC;
  localparam logic [3:0] F_PRIO = 4'hD;
  localparam logic [3:0] F_DATA0 = 4'h4;
  localparam logic [3:0] MB_STRUCT = 4'hD;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MCTL1_CLOCK_SOURCE_SELECT = 0;
  localparam int STAT_IDLE = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_LOST = 2;

  // ****************************************
  // Bus framing counts
  // ****************************************
  localparam logic [3:0] IDLE_BITS = 4'hB;
  localparam logic [2:0] EOF_BITS = 3'h7;
  localparam logic [6:0] RX_BITS = 7'h68;
  localparam logic [5:0] HLEN_STD = 6'h13;
  localparam logic [5:0] HLEN_EXT = 6'h27;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cbm_cpu_req_s;

  typedef struct packed {
    logic [3:0] nbits;
    logic [7:0] bits;
  } cbm_chunk_s;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_ARB = 4'h2,
    TX_SEND = 4'h4,
    TX_DONE = 4'h8
  } cbm_tx_e;

  // Every length field holds its length minus one
  function automatic logic [4:0] seg_a_len(input logic [7:0] bt1);
    return {1'b0, bt1[3:0]} + 5'h1;
  endfunction

  function automatic logic [3:0] seg_b_len(input logic [7:0] bt1);
    return {1'b0, bt1[6:4]} + 4'h1;
  endfunction

  function automatic logic [2:0] sjw_len(input logic [7:0] bt0);
    return {1'b0, bt0[7:6]} + 3'h1;
  endfunction

endpackage

// [rtl/cbm_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides and a flush input.
  Assumes one clock and a reset already synchronised to it.
*/
`timescale 1ns/10ps
`default_nettype none

module cbm_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("cbm_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } cbm_fifo_st_s;

  cbm_fifo_st_s st_r;
  cbm_fifo_st_s st_nxt;
  logic push;
  logic pop;

  assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data = st_r.mem[st_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (clear) begin
      st_nxt.wp = '0;
      st_nxt.rp = '0;
      st_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  property p_fill_stalls;
    @(posedge clk) disable iff (!rst_n)
    (push && !pop && !clear && st_r.cnt == (AW+1)'(DEPTH - 1)) |=> !in_ready;
  endproperty
  a_fill_stalls: assert property (p_fill_stalls) else $error("fifo full not refused");

endmodule
`default_nettype wire

// [rtl/cbm_can_top.sv]
/*
  CAN bit timing generator, message buffers and transmit serialiser.
  Assumes the 128-byte window select is decoded outside; the CPU port runs
  on clk; CAN pins and the oscillator come from outside the clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// [R1] Bit rates from 10 kbps to 1 Mbps through prescaler and segments.
// [R2] Source select bit picks oscillator or twice the bus clock; the code takes clk itself when set, one tick per cycle.
// [R3] Integrator supplies a 0.4 percent, 50 percent duty source clock.
// [R4] Prescaler divides source clock into quanta; bit rate is fTq/quanta.
// [R5] Every bit starts with a one-quantum sync segment.
// [R6] First segment programmable from 4 to 16 quanta.
// [R7] Second segment programmable from 2 to 8 quanta.
// [R8] Jump width programmable from 1 to 4 quanta.
// [R9] Each length field holds its length minus one.
// [R10] Software programs standard-compliant timing values.
// [R11] Registers fill one 128-byte window.
// [R12] Background receive buffer readable only in test mode.
// [R13] Receive buffer at 0x40, transmit buffers at 0x50, 0x60, 0x70.
// [R14] Buffer: 13-byte frame, priority byte, two unused bytes.
// [R15] Receive and transmit buffers share one layout.
// [R16] Frame bytes of all buffers have no reset.
// [R17] Receive buffer ignores writes; transmit buffers read and write.
// [R18] Identifier 0-3, data 4-B, length C, priority D.
// [R19] Priority byte is used only in transmit buffers.
// [R20] Identifier holds 11-bit or 29-bit forms.
// [R21] Extended identifier layout with SRR, IDE and RTR bits.
// [R22] Identifier sent MSB first; smaller value wins arbitration.
// [R23] Smallest identifier value is highest priority.
// [R24] Extension flag 0 means standard, 1 means extended.
// [R25] Length code gives 0 to 8 data bytes; remote frames send none.
// [R26] Lowest local priority sent first, ties to lowest index.
// [R27] Standard identifier in byte 0 and top of byte 1, then flags.
// [R28] Data sent from byte 0, MSB first, as many as the length code.
module cbm_can_top #(
  parameter int PRESC_W = cbm_pkg::PRESC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // CPU register port
  input wire cbm_pkg::cbm_cpu_req_s cpu_req,
  output logic [7:0] cpu_rdata,
  input wire logic test_mode,
  // Clock source and CAN pins
  input wire logic osc_clock_in,
  input wire logic can_rx_pin,
  output logic can_tx_pin
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (PRESC_W < 6 || PRESC_W > 14) begin : g_pw
    $error("cbm_can_top: PRESC_W out of range");
  end
  // Slowest rate with the longest bit must reach the lower bound (see [R1])
  if (cbm_pkg::CLK_MHZ * 1000 / ((1 << PRESC_W) * cbm_pkg::MAX_BIT_TQ)
      > cbm_pkg::RATE_MIN_KBPS) begin : g_slow
    $error("cbm_can_top: prescaler too narrow for lowest rate");
  end
  if (cbm_pkg::CLK_MHZ * 1000 / cbm_pkg::MIN_BIT_TQ
      < cbm_pkg::RATE_MAX_KBPS) begin : g_fast
    $error("cbm_can_top: clock too slow for highest rate");
  end

  typedef struct packed {
    logic [7:0] mctl1;
    logic [7:0] bt0;
    logic [7:0] bt1;
    logic [7:0] presc_hi;
    logic [2:0] tx_req;
    logic lost;
    logic [7:0] rdata;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic [PRESC_W-1:0] pcnt;
    logic [5:0] cnt;
    logic [5:0] a_end;
    logic [5:0] b_end;
    logic [3:0] idle_cnt;
    logic rx_act;
    logic [6:0] rx_ptr;
    logic [2:0] rec_run;
    logic copy;
    cbm_pkg::cbm_tx_e tx_st;
    logic [1:0] tx_sel;
    logic [3:0] ld_idx;
    logic [7:0] sh;
    logic [3:0] sh_cnt;
    logic tx_pin;
  } cbm_top_ctl_s;

  // Index 0 is the foreground receive buffer, 1 to 3 the transmit buffers
  typedef struct packed {
    cbm_top_ctl_s c;
    logic [3:0][13:0][7:0] mb;
    logic [12:0][7:0] bg;
  } cbm_top_st_s;

  cbm_top_st_s st_r;
  cbm_top_st_s st_nxt;
  logic rst_q1;
  logic rst_n;

  logic [4:0] sa;
  logic [3:0] sb;
  logic [2:0] sj;
  logic [PRESC_W-1:0] presc;
  logic src_tick;
  logic tq_tick;
  logic samp_pt;
  logic bit_end;
  logic fall;
  logic bus_idle;
  logic [5:0] adj;
  logic [1:0] win_sel;
  logic any_req;
  logic [13:0][7:0] tb;
  logic ext;
  logic rtr;
  logic [39:0] hdr;
  logic [3:0] nhdr;
  logic [3:0] nbytes;
  logic [3:0] nitems;
  cbm_pkg::cbm_chunk_s item;
  cbm_pkg::cbm_chunk_s head;
  cbm_pkg::cbm_chunk_s head_q;
  logic push;
  logic fifo_ready;
  logic fifo_valid;
  logic pop;
  logic fifo_clr;
  logic [2:0] bk;
  logic [3:0] by;
  logic [7:0] rv;

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ****************************************
  // Timing decode
  // ****************************************
  assign sa = cbm_pkg::seg_a_len(st_r.c.bt1); // see [R6] see [R9]
  assign sb = cbm_pkg::seg_b_len(st_r.c.bt1); // see [R7] see [R9]
  assign sj = cbm_pkg::sjw_len(st_r.c.bt0); // see [R8] see [R9]
  assign presc = {st_r.c.presc_hi[PRESC_W-7:0], st_r.c.bt0[5:0]};
  // Oscillator edges arrive late by the synchroniser; phase is irrelevant
  assign src_tick = st_r.c.mctl1[cbm_pkg::MCTL1_CLOCK_SOURCE_SELECT]
                    || (st_r.c.osc_s2 && !st_r.c.osc_s3); // see [R2]
  assign tq_tick = src_tick && (st_r.c.pcnt == presc); // see [R4]
  assign samp_pt = tq_tick && (st_r.c.cnt == st_r.c.a_end);
  assign bit_end = tq_tick && (st_r.c.cnt == st_r.c.b_end);
  // Edges we caused by driving dominant are not used to resynchronise
  assign fall = st_r.c.rx_s3 && !st_r.c.rx_s2 && st_r.c.tx_pin;
  assign bus_idle = (st_r.c.idle_cnt == cbm_pkg::IDLE_BITS);
  assign adj = (st_r.c.cnt < 6'(sj)) ? st_r.c.cnt : 6'(sj);

  // ****************************************
  // Transmit buffer choice and frame header
  // ****************************************
  always_comb begin
    win_sel = 2'h0;
    any_req = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (st_r.c.tx_req[i] && (!any_req
          || st_r.mb[i+1][cbm_pkg::F_PRIO] < st_r.mb[win_sel+2'h1][cbm_pkg::F_PRIO])) begin
        win_sel = 2'(i); // see [R26]
        any_req = 1'b1;
      end
    end
  end

  assign tb = st_r.mb[st_r.c.tx_sel + 2'h1];
  assign ext = tb[1][3]; // see [R24]
  assign rtr = ext ? tb[3][0] : tb[1][4];
  // Identifier bytes already hold the bit order of the wire (see [R21] see [R22])
  assign hdr = ext ? {1'b0, tb[0], tb[1], tb[2], tb[3], 2'h0, tb[cbm_pkg::F_DLC][3:0], 1'b0}
             : {1'b0, tb[0], tb[1][7:4], 2'h0, tb[cbm_pkg::F_DLC][3:0], 21'h0}; // see [R27]
  assign nhdr = ext ? 4'h5 : 4'h3; // see [R20]
  // Codes above eight still send eight bytes (see [R25])
  assign nbytes = rtr ? 4'h0
                : (tb[cbm_pkg::F_DLC][3:0] > 4'h8) ? 4'h8 : tb[cbm_pkg::F_DLC][3:0];
  assign nitems = nhdr + nbytes;

  always_comb begin
    head.bits = 8'(hdr >> (7'h20 - {st_r.c.ld_idx, 3'h0}));
    head.nbits = 4'h8;
    if (st_r.c.ld_idx == nhdr - 4'h1) begin
      head.nbits = 4'(ext ? cbm_pkg::HLEN_EXT : cbm_pkg::HLEN_STD) & 4'h7;
    end
    item = head;
    if (st_r.c.ld_idx >= nhdr) begin
      item.bits = tb[cbm_pkg::F_DATA0 + st_r.c.ld_idx - nhdr]; // see [R28]
      item.nbits = 4'h8;
    end
  end

  assign push = (st_r.c.tx_st == cbm_pkg::TX_SEND) && (st_r.c.ld_idx < nitems);
  assign pop = bit_end && (st_r.c.tx_st == cbm_pkg::TX_SEND)
               && (st_r.c.sh_cnt <= 4'h1) && fifo_valid;
  assign fifo_clr = samp_pt && (st_r.c.tx_st == cbm_pkg::TX_SEND)
                    && st_r.c.tx_pin && !st_r.c.rx_s2;

  cbm_fifo #(
    .W($bits(cbm_pkg::cbm_chunk_s)),
    .DEPTH(8)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .clear(fifo_clr),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(item),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(head_q)
  );

  // ****************************************
  // CPU read decode
  // ****************************************
  always_comb begin
    bk = cpu_req.addr[6:4];
    by = cpu_req.addr[3:0];
    rv = 8'h00;
    if (cpu_req.addr == cbm_pkg::OFS_MCTL1) begin
      rv = st_r.c.mctl1;
    end else if (cpu_req.addr == cbm_pkg::OFS_BT0) begin
      rv = st_r.c.bt0;
    end else if (cpu_req.addr == cbm_pkg::OFS_BT1) begin
      rv = st_r.c.bt1;
    end else if (cpu_req.addr == cbm_pkg::OFS_PRESC_HI) begin
      rv = st_r.c.presc_hi;
    end else if (cpu_req.addr == cbm_pkg::OFS_TXREQ) begin
      rv = {5'h0, st_r.c.tx_req};
    end else if (cpu_req.addr == cbm_pkg::OFS_STAT) begin
      rv = {5'h0, st_r.c.lost, st_r.c.tx_st != cbm_pkg::TX_IDLE, bus_idle};
    end else if (bk == cbm_pkg::BUF_RX) begin
      if (test_mode && by < cbm_pkg::MB_STRUCT) begin
        rv = st_r.bg[by]; // see [R12]
      end else if (!test_mode && by < cbm_pkg::F_PRIO) begin
        rv = st_r.mb[0][by]; // see [R19]
      end
    end else if (bk > cbm_pkg::BUF_RX && by <= cbm_pkg::F_PRIO) begin // see [R14]
      rv = st_r.mb[2'(bk - cbm_pkg::BUF_RX)][by]; // see [R13] see [R15] see [R18]
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.c.osc_s1 = osc_clock_in;
    st_nxt.c.osc_s2 = st_r.c.osc_s1;
    st_nxt.c.osc_s3 = st_r.c.osc_s2;
    st_nxt.c.rx_s1 = can_rx_pin;
    st_nxt.c.rx_s2 = st_r.c.rx_s1;
    st_nxt.c.rx_s3 = st_r.c.rx_s2;
    st_nxt.c.copy = 1'b0;
    if (src_tick) begin
      st_nxt.c.pcnt = (st_r.c.pcnt == presc) ? '0 : st_r.c.pcnt + 1'b1;
    end
    // Bit timer: hard sync when idle, bounded resync while receiving
    if (fall && bus_idle && !st_r.c.rx_act) begin
      st_nxt.c.cnt = 6'h1;
      st_nxt.c.a_end = 6'(sa);
      st_nxt.c.b_end = 6'(sa) + 6'(sb);
    end else if (fall && st_r.c.rx_act && st_r.c.cnt != 6'h0) begin
      if (st_r.c.cnt <= st_r.c.a_end) begin
        st_nxt.c.a_end = st_r.c.a_end + adj; // see [R8]
        st_nxt.c.b_end = st_r.c.b_end + adj;
      end else if (st_r.c.b_end - st_r.c.cnt < 6'(sj)) begin
        st_nxt.c.b_end = st_r.c.cnt;
      end else begin
        st_nxt.c.b_end = st_r.c.b_end - 6'(sj);
      end
    end else if (tq_tick) begin
      if (bit_end) begin
        st_nxt.c.cnt = 6'h0; // see [R5]
        st_nxt.c.a_end = 6'(sa); // see [R6]
        st_nxt.c.b_end = 6'(sa) + 6'(sb); // see [R7]
      end else begin
        st_nxt.c.cnt = st_r.c.cnt + 6'h1;
      end
    end
    // Receiver keeps raw bits after start of frame, own frames included
    if (samp_pt) begin
      if (!st_r.c.rx_s2) begin
        st_nxt.c.idle_cnt = 4'h0;
      end else if (!bus_idle) begin
        st_nxt.c.idle_cnt = st_r.c.idle_cnt + 4'h1;
      end
      if (!st_r.c.rx_act && bus_idle && !st_r.c.rx_s2) begin
        st_nxt.c.rx_act = 1'b1;
        st_nxt.c.rx_ptr = 7'h0;
        st_nxt.c.rec_run = 3'h0;
      end else if (st_r.c.rx_act) begin
        if (st_r.c.rx_ptr < cbm_pkg::RX_BITS) begin
          st_nxt.bg[st_r.c.rx_ptr[6:3]][~st_r.c.rx_ptr[2:0]] = st_r.c.rx_s2;
          st_nxt.c.rx_ptr = st_r.c.rx_ptr + 7'h1;
        end
        st_nxt.c.rec_run = st_r.c.rx_s2 ? st_r.c.rec_run + 3'h1 : 3'h0;
        if (st_r.c.rx_s2 && st_r.c.rec_run == cbm_pkg::EOF_BITS - 3'h1) begin
          st_nxt.c.rx_act = 1'b0;
          st_nxt.c.copy = 1'b1;
        end
      end
    end
    if (st_r.c.copy) begin
      st_nxt.mb[0][12:0] = st_r.bg;
    end
    // Transmit sequencer
    if (push && fifo_ready) begin
      st_nxt.c.ld_idx = st_r.c.ld_idx + 4'h1;
    end
    case (st_r.c.tx_st)
      cbm_pkg::TX_IDLE: begin
        if (any_req && bus_idle && !st_r.c.rx_act) begin
          st_nxt.c.tx_st = cbm_pkg::TX_ARB;
        end
      end
      cbm_pkg::TX_ARB: begin
        st_nxt.c.tx_sel = win_sel; // see [R26]
        if (!any_req || !bus_idle) begin
          st_nxt.c.tx_st = cbm_pkg::TX_IDLE;
        end else if (bit_end) begin
          st_nxt.c.tx_st = cbm_pkg::TX_SEND;
          st_nxt.c.ld_idx = 4'h0;
        end
      end
      cbm_pkg::TX_SEND: begin
        if (fifo_clr) begin
          st_nxt.c.lost = 1'b1; // see [R22] see [R23]
          st_nxt.c.tx_pin = 1'b1;
          st_nxt.c.sh_cnt = 4'h0;
          st_nxt.c.tx_st = cbm_pkg::TX_IDLE;
        end else if (bit_end && st_r.c.sh_cnt > 4'h1) begin
          st_nxt.c.sh = {st_r.c.sh[6:0], 1'b0};
          st_nxt.c.tx_pin = st_r.c.sh[6]; // see [R22] see [R28]
          st_nxt.c.sh_cnt = st_r.c.sh_cnt - 4'h1;
        end else if (pop) begin
          st_nxt.c.sh = head_q.bits;
          st_nxt.c.tx_pin = head_q.bits[7];
          st_nxt.c.sh_cnt = head_q.nbits;
        end else if (bit_end) begin
          st_nxt.c.tx_pin = 1'b1;
          st_nxt.c.sh_cnt = 4'h0;
          if (st_r.c.ld_idx == nitems) begin
            st_nxt.c.tx_st = cbm_pkg::TX_DONE;
          end
        end
      end
      cbm_pkg::TX_DONE: begin
        st_nxt.c.tx_req[st_r.c.tx_sel] = 1'b0;
        st_nxt.c.tx_st = cbm_pkg::TX_IDLE;
      end
      default: begin
        st_nxt.c.tx_st = cbm_pkg::TX_IDLE;
      end
    endcase
    // CPU access last so that a request set wins over the completion clear
    if (cpu_req.sel && !cpu_req.wr) begin
      st_nxt.c.rdata = rv; // see [R11]
    end
    if (cpu_req.sel && cpu_req.wr) begin
      if (cpu_req.addr == cbm_pkg::OFS_MCTL1) begin
        st_nxt.c.mctl1 = cpu_req.wdata;
      end else if (cpu_req.addr == cbm_pkg::OFS_BT0) begin
        st_nxt.c.bt0 = cpu_req.wdata;
      end else if (cpu_req.addr == cbm_pkg::OFS_BT1) begin
        st_nxt.c.bt1 = cpu_req.wdata;
      end else if (cpu_req.addr == cbm_pkg::OFS_PRESC_HI) begin
        st_nxt.c.presc_hi = cpu_req.wdata;
      end else if (cpu_req.addr == cbm_pkg::OFS_TXREQ) begin
        st_nxt.c.tx_req = st_nxt.c.tx_req | cpu_req.wdata[2:0];
      end else if (cpu_req.addr == cbm_pkg::OFS_STAT) begin
        if (cpu_req.wdata[cbm_pkg::STAT_LOST] && !fifo_clr) begin
          st_nxt.c.lost = 1'b0;
        end
      end else if (cpu_req.addr[6:4] > cbm_pkg::BUF_RX
                   && cpu_req.addr[3:0] <= cbm_pkg::F_PRIO) begin
        // Receive buffer falls outside this branch, so its writes are lost (see [R17])
        st_nxt.mb[2'(cpu_req.addr[6:4] - cbm_pkg::BUF_RX)][cpu_req.addr[3:0]] = cpu_req.wdata;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Buffers stay out of the reset branch: their contents start undefined
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.c <= '0; // see [R16]
      st_r.c.rx_s1 <= 1'b1;
      st_r.c.rx_s2 <= 1'b1;
      st_r.c.rx_s3 <= 1'b1;
      st_r.c.tx_pin <= 1'b1;
      st_r.c.tx_st <= cbm_pkg::TX_IDLE;
      // Long first bit: equal zero ends would give a bit with no sync segment
      st_r.c.b_end <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cpu_rdata = st_r.c.rdata;
  assign can_tx_pin = st_r.c.tx_pin;

  // ****************************************
  // Checks
  // ****************************************
  property p_sync_seg;
    @(posedge clk) disable iff (!rst_n)
    (tq_tick && st_r.c.cnt == 6'h0 && !fall) |=> (st_r.c.cnt == 6'h1);
  endproperty
  a_sync_seg: assert property (p_sync_seg) else $error("sync segment not one quantum"); // see [R5]

  property p_seg_a;
    @(posedge clk) disable iff (!rst_n)
    (bit_end && !fall) |=> (st_r.c.a_end == 6'(cbm_pkg::seg_a_len($past(st_r.c.bt1))));
  endproperty
  a_seg_a: assert property (p_seg_a) else $error("first segment length wrong"); // see [R6]

  property p_seg_b;
    @(posedge clk) disable iff (!rst_n)
    (bit_end && !fall)
      |=> (st_r.c.b_end - st_r.c.a_end == 6'(cbm_pkg::seg_b_len($past(st_r.c.bt1))));
  endproperty
  a_seg_b: assert property (p_seg_b) else $error("second segment length wrong"); // see [R7]

  property p_jump;
    @(posedge clk) disable iff (!rst_n)
    samp_pt |-> (st_r.c.a_end <= 6'(sa) + 6'(sj));
  endproperty
  a_jump: assert property (p_jump) else $error("resync beyond jump width"); // see [R8]

  property p_rx_ro;
    @(posedge clk) disable iff (!rst_n)
    (cpu_req.sel && cpu_req.wr && cpu_req.addr[6:4] == cbm_pkg::BUF_RX && !st_r.c.copy)
      |=> (st_r.mb[0] === $past(st_r.mb[0]));
  endproperty
  a_rx_ro: assert property (p_rx_ro) else $error("receive buffer took a write"); // see [R17]

  property p_rx_prio;
    @(posedge clk) disable iff (!rst_n)
    (cpu_req.sel && !cpu_req.wr && !test_mode
     && cpu_req.addr == {cbm_pkg::BUF_RX, cbm_pkg::F_PRIO}) |=> (cpu_rdata == 8'h00);
  endproperty
  a_rx_prio: assert property (p_rx_prio) else $error("receive priority byte not zero"); // see [R19]

  property p_test_view;
    @(posedge clk) disable iff (!rst_n)
    (cpu_req.sel && !cpu_req.wr && !test_mode
     && cpu_req.addr == {cbm_pkg::BUF_RX, 4'h0}) |=> (cpu_rdata == $past(st_r.mb[0][0]));
  endproperty
  a_test_view: assert property (p_test_view) else $error("background seen outside test"); // see [R12]

  property p_pick;
    @(posedge clk) disable iff (!rst_n)
    (st_r.c.tx_st == cbm_pkg::TX_ARB && st_nxt.c.tx_st == cbm_pkg::TX_SEND)
      |=> (st_r.c.tx_req[st_r.c.tx_sel]);
  endproperty
  a_pick: assert property (p_pick) else $error("idle buffer chosen to send"); // see [R26]

  property p_remote;
    @(posedge clk) disable iff (!rst_n)
    (st_r.c.tx_st == cbm_pkg::TX_SEND && rtr) |-> (nitems == nhdr);
  endproperty
  a_remote: assert property (p_remote) else $error("remote frame with data"); // see [R25]

endmodule
`default_nettype wire

// [sim/cbm_bus_model.sv]
/* Far side of the CAN pins: the bus as a wired-AND of this node and one other.
   Assumes 1 is recessive and that other nodes only pull the bus dominant. */
`timescale 1ns/10ps
`default_nettype none
module cbm_bus_model (
  // Bus lines
  input wire logic tx_pin,
  input wire logic other_dom,
  output logic rx_pin
);
  // Dominant from any node wins the wire, as in arbitration
  assign rx_pin = tx_pin & ~other_dom;
endmodule
`default_nettype wire

// [sim/can_bit_timing_and_msg_buffers_bench.sv]
/* Register-level bench of the CAN block, looping its own frame back.
   Assumes the block's register map and clk as the quantum source. */
`timescale 1ns/10ps
`default_nettype none
module can_bit_timing_and_msg_buffers_bench;
  // ****************************************
  // Harness
  // ****************************************
  logic clk, arst_n, test_mode, osc, tx_pin, rx_pin, other_dom;
  cbm_pkg::cbm_cpu_req_s req;
  logic [7:0] rdata, v;
  int n_fail, tests_run;
  cbm_can_top uut (.clk(clk), .arst_n(arst_n), .cpu_req(req), .cpu_rdata(rdata),
    .test_mode(test_mode), .osc_clock_in(osc), .can_rx_pin(rx_pin), .can_tx_pin(tx_pin));
  cbm_bus_model bus (.tx_pin(tx_pin), .other_dom(other_dom), .rx_pin(rx_pin));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    forever #7 osc = ~osc;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One access per two cycles keeps sel from toggling twice in a time step
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{sel: 1'b1, wr: w, addr: a, wdata: d};
    @(negedge clk);
    req.sel = 1'b0;
    v = rdata;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(v, exp);
  endtask
  task automatic poll(input logic [6:0] a, input logic [7:0] m, input logic [7:0] exp);
    for (int i = 0; i < 3000; i++) begin
      acc(1'b0, a, 8'h00);
      if ((v & m) === exp) break;
    end
    chk(v & m, exp);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    results;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    n_fail = 0;
    tests_run = 0;
    arst_n = 1'b0;
    test_mode = 1'b0;
    other_dom = 1'b0;
    req = '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int a = 1; a < 6; a++) rd(7'(a), 8'h00);
    acc(1'b1, 7'h02, 8'hC0);
    rd(7'h02, 8'hC0);
    acc(1'b1, 7'h02, 8'h00);
    // Second segment 2 quanta, first 5, jump width 1
    acc(1'b1, 7'h03, 8'h14);
    rd(7'h03, 8'h14);
    acc(1'b1, 7'h01, 8'h01);
    rd(7'h01, 8'h01);
    for (int b = 5; b < 8; b++) begin
      for (int o = 0; o < 14; o++) acc(1'b1, 7'(b * 16 + o), 8'(b * 16 + o + 17));
      for (int o = 0; o < 14; o++) rd(7'(b * 16 + o), 8'(b * 16 + o + 17));
      acc(1'b1, 7'(b * 16 + 14), 8'hFF);
      rd(7'(b * 16 + 14), 8'h00);
    end
    rd(7'h10, 8'h00);
    // Standard data frame: id 0x528, one byte 0x3C
    acc(1'b1, 7'h50, 8'hA5);
    acc(1'b1, 7'h51, 8'h00);
    acc(1'b1, 7'h54, 8'h3C);
    acc(1'b1, 7'h5C, 8'h01);
    acc(1'b1, 7'h05, 8'h01);
    poll(7'h05, 8'h01, 8'h00);
    poll(7'h06, 8'h01, 8'h01);
    rd(7'h40, 8'hA5);
    rd(7'h41, 8'h00);
    rd(7'h42, 8'h4F);
    rd(7'h4D, 8'h00);
    // Background byte 3: last two data bits, then recessive tail
    test_mode = 1'b1;
    rd(7'h43, 8'h3F);
    test_mode = 1'b0;
    acc(1'b1, 7'h40, 8'h5A);
    rd(7'h40, 8'hA5);
    // Another node holds the bus dominant from start of frame: we lose at ID10
    acc(1'b1, 7'h05, 8'h01);
    @(negedge tx_pin);
    repeat (2) @(negedge clk);
    other_dom = 1'b1;
    poll(7'h06, 8'h04, 8'h04);
    other_dom = 1'b0;
    rd(7'h05, 8'h01);
    acc(1'b1, 7'h06, 8'h04);
    rd(7'h06, 8'h00);
    // Retry once the bus is idle again, then the own frame lands once more
    poll(7'h05, 8'h01, 8'h00);
    poll(7'h06, 8'h01, 8'h01);
    rd(7'h40, 8'hA5);
    results;
  end
endmodule
`default_nettype wire
